// ==== hw/jbt_pkg.sv ====
// constants and types shared by the boundary-scan test access port
package jbt_pkg;

  // register lengths
  localparam int unsigned JBT_IR_W    = 3;    // instruction register length
  localparam int unsigned JBT_ID_W    = 32;   // device code register length
  localparam int unsigned JBT_BS_W    = 109;  // boundary scan chain length

  // instruction codes
  localparam logic [2:0]  JBT_INS_EXTEST  = 3'h0;  // drive preloaded pattern on pads
  localparam logic [2:0]  JBT_INS_IDCODE  = 3'h1;  // shift the device code
  localparam logic [2:0]  JBT_INS_SAMPLEZ = 3'h2;  // sample with outputs floating
  localparam logic [2:0]  JBT_INS_SAMPLE  = 3'h4;  // sample / preload
  localparam logic [2:0]  JBT_INS_BYPASS  = 3'h7;  // single bypass cell

  // values after reset and at capture
  localparam logic [2:0]  JBT_IR_RESET    = 3'h1;  // device code selected at reset
  localparam logic [2:0]  JBT_IR_CAPTURE  = 3'h1;  // fixed pattern loaded at capture-ir
  localparam logic [31:0] JBT_ID_VALUE    = 32'h0a5c_3e71;  // arbitrary neutral code
  localparam logic [108:0] JBT_BS_RESET   = '0;  // boundary registers after reset
  localparam int unsigned JBT_SYNC_STAGES = 2;   // flops in each synchroniser

  // tap controller states, standard encoding
  typedef enum logic [3:0] {
    JBT_ST_E2DR = 4'h0,
    JBT_ST_E1DR = 4'h1,
    JBT_ST_SDR  = 4'h2,
    JBT_ST_PDR  = 4'h3,
    JBT_ST_SIRS = 4'h4,
    JBT_ST_UDR  = 4'h5,
    JBT_ST_CDR  = 4'h6,
    JBT_ST_SDRS = 4'h7,
    JBT_ST_E2IR = 4'h8,
    JBT_ST_E1IR = 4'h9,
    JBT_ST_SIR  = 4'ha,
    JBT_ST_PIR  = 4'hb,
    JBT_ST_RTI  = 4'hc,
    JBT_ST_UIR  = 4'hd,
    JBT_ST_CIR  = 4'he,
    JBT_ST_TLR  = 4'hf
  } jbt_state_e;

endpackage

// ==== hw/jbt_tap.sv ====
// boundary-scan test access port with instruction, bypass, device code and boundary registers
//
// Contract
// RQ1: provide 3/1/32/109-bit registers between tdi, tdo
// RQ2: code 000 drives preloaded outputs, captures inputs
// RQ3: controller preloads first vector before external test
// RQ4: code 001 captures device code, shifts it
// RQ5: device code active at reset and test-logic-reset
// RQ6: code 010 floats outputs, captures, shifts chain
// RQ7: controller never loads codes 011, 101, 110
// RQ8: code 100 captures input buffers, shifts chain
// RQ9: sampling changing inputs is harmless, maybe unrepeatable
// RQ10: code 111 puts bypass cell in path
// RQ11: memory output register undefined during external test
// RQ12: power-up needed after external test
// RQ13: inputs stable around capture window
// RQ14: clock-recovery initialisation after scan activity
// RQ15: five tms-high edges or power-up reset port
// RQ16: tms, tdi on rising tck; tdo on falling
// RQ17: sixteen-state controller, lsb-first shifting
// RQ18: tdo driven only in shift-ir and shift-dr
`timescale 1ns/1ns
module jbt_tap (
  input  wire logic                           clk_sys,          // memory core clock
  input  wire logic                           resetn,           // power-up reset, active low
  input  wire logic                           tck,              // test clock
  input  wire logic                           tms,              // test mode select
  input  wire logic                           tdi,              // test data in
  output logic                                tdo_q,            // test data out
  output logic                                tdo_oe_q,         // tdo output enable
  input  wire logic [jbt_pkg::JBT_BS_W-1:0]   bs_pad_in,        // levels at the balls
  output logic      [jbt_pkg::JBT_BS_W-1:0]   bs_pad_out_q,     // values driven in external test
  output logic                                bs_drive_q,       // boundary cells own the outputs
  output logic                                bs_float_q,       // all memory outputs high-z
  output logic                                core_test_hold_q, // core sees test mode, clk_sys
  output logic                                core_float_q      // core sees outputs floating
);
  import jbt_pkg::*;

  // tck domain state
  jbt_state_e                 st_q, st_d;          // controller state
  logic [JBT_IR_W-1:0]        ir_sh_q, ir_sh_d;    // instruction shift stage
  logic [JBT_IR_W-1:0]        ir_q, ir_d;          // active instruction
  logic                       byp_q, byp_d;        // bypass cell
  logic [JBT_ID_W-1:0]        id_sh_q, id_sh_d;    // device code shift register
  logic [JBT_BS_W-1:0]        bs_sh_q, bs_sh_d;    // boundary shift stage
  logic [JBT_BS_W-1:0]        bs_out_d;            // boundary update stage next
  logic                       drive_d, float_d;    // output mode next
  logic [JBT_BS_W-1:0]        pad_m_q;             // pad synchroniser first stage
  logic [JBT_BS_W-1:0]        pad_s_q;             // pad synchroniser second stage
  logic                       tdo_d, tdo_oe_d;     // falling edge output next
  logic                       hold_src_q;          // drive or float, one flop so the crossing sees no glitch
  // clk_sys domain synchronisers
  logic                       hold_m_q, float_m_q; // first stages
  logic                       dr_boundary;         // boundary chain selected

  // next controller state from tms
  function automatic jbt_state_e next_state(input jbt_state_e s, input logic m);
    case (s)
      JBT_ST_TLR:  next_state = m ? JBT_ST_TLR  : JBT_ST_RTI;
      JBT_ST_RTI:  next_state = m ? JBT_ST_SDRS : JBT_ST_RTI;
      JBT_ST_SDRS: next_state = m ? JBT_ST_SIRS : JBT_ST_CDR;
      JBT_ST_CDR:  next_state = m ? JBT_ST_E1DR : JBT_ST_SDR;
      JBT_ST_SDR:  next_state = m ? JBT_ST_E1DR : JBT_ST_SDR;
      JBT_ST_E1DR: next_state = m ? JBT_ST_UDR  : JBT_ST_PDR;
      JBT_ST_PDR:  next_state = m ? JBT_ST_E2DR : JBT_ST_PDR;
      JBT_ST_E2DR: next_state = m ? JBT_ST_UDR  : JBT_ST_SDR;
      JBT_ST_UDR:  next_state = m ? JBT_ST_SDRS : JBT_ST_RTI;
      JBT_ST_SIRS: next_state = m ? JBT_ST_TLR  : JBT_ST_CIR;
      JBT_ST_CIR:  next_state = m ? JBT_ST_E1IR : JBT_ST_SIR;
      JBT_ST_SIR:  next_state = m ? JBT_ST_E1IR : JBT_ST_SIR;
      JBT_ST_E1IR: next_state = m ? JBT_ST_UIR  : JBT_ST_PIR;
      JBT_ST_PIR:  next_state = m ? JBT_ST_E2IR : JBT_ST_PIR;
      JBT_ST_E2IR: next_state = m ? JBT_ST_UIR  : JBT_ST_SIR;
      JBT_ST_UIR:  next_state = m ? JBT_ST_SDRS : JBT_ST_RTI;
      default:     next_state = JBT_ST_TLR;
    endcase
  endfunction

  // boundary chain serves external test and both sample codes
  assign dr_boundary = (ir_q == JBT_INS_EXTEST) || (ir_q == JBT_INS_SAMPLE)
                    || (ir_q == JBT_INS_SAMPLEZ);

  // next values of the rising edge group
  always_comb
  begin
    st_d     = next_state(st_q, tms);   // RQ17 RQ15
    ir_sh_d  = ir_sh_q;
    ir_d     = ir_q;
    byp_d    = byp_q;
    id_sh_d  = id_sh_q;
    bs_sh_d  = bs_sh_q;
    bs_out_d = bs_pad_out_q;
    drive_d  = bs_drive_q;
    float_d  = bs_float_q;
    case (st_q)
      // reset selects the device code and releases the pads
      JBT_ST_TLR:
      begin
        ir_d    = JBT_IR_RESET;         // RQ5
        drive_d = 1'b0;
        float_d = 1'b0;
      end
      // instruction path
      JBT_ST_CIR:
        ir_sh_d = JBT_IR_CAPTURE;
      JBT_ST_SIR:
        ir_sh_d = {tdi, ir_sh_q[JBT_IR_W-1:1]};  // RQ17
      JBT_ST_UIR:
      begin
        ir_d    = ir_sh_q;
        drive_d = (ir_sh_q == JBT_INS_EXTEST);   // RQ2
        float_d = (ir_sh_q == JBT_INS_SAMPLEZ);  // RQ6
      end
      // data capture per instruction
      JBT_ST_CDR:
      begin
        if (ir_q == JBT_INS_IDCODE)
          id_sh_d = JBT_ID_VALUE;       // RQ4
        else if (dr_boundary)
          bs_sh_d = pad_s_q;            // RQ2 RQ6 RQ8 RQ9
        else
          byp_d = 1'b0;                 // RQ10
      end
      // data shift, lsb toward tdo
      JBT_ST_SDR:
      begin
        if (ir_q == JBT_INS_IDCODE)
          id_sh_d = {tdi, id_sh_q[JBT_ID_W-1:1]};  // RQ4
        else if (dr_boundary)
          bs_sh_d = {tdi, bs_sh_q[JBT_BS_W-1:1]};  // RQ8
        else
          byp_d = tdi;                  // RQ10
      end
      // preload or external test pattern update
      JBT_ST_UDR:
      begin
        if (dr_boundary)
          bs_out_d = bs_sh_q;           // RQ2
      end
      default:
      begin
        st_d = st_d;
      end
    endcase
  end

  // registers of the rising edge group, power-up reset
  always_ff @(posedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q         <= JBT_ST_TLR;       // RQ15
      ir_sh_q      <= JBT_IR_RESET;
      ir_q         <= JBT_IR_RESET;     // RQ5
      byp_q        <= 1'b0;
      id_sh_q      <= '0;
      bs_sh_q      <= JBT_BS_RESET;
      bs_pad_out_q <= JBT_BS_RESET;
      bs_drive_q   <= 1'b0;
      bs_float_q   <= 1'b0;
      pad_m_q      <= '0;
      pad_s_q      <= '0;
      hold_src_q   <= 1'b0;
    end
    else
    begin
      st_q         <= st_d;             // RQ16
      ir_sh_q      <= ir_sh_d;
      ir_q         <= ir_d;
      byp_q        <= byp_d;
      id_sh_q      <= id_sh_d;
      bs_sh_q      <= bs_sh_d;
      bs_pad_out_q <= bs_out_d;
      bs_drive_q   <= drive_d;
      bs_float_q   <= float_d;
      pad_m_q      <= bs_pad_in;        // RQ9
      pad_s_q      <= pad_m_q;
      hold_src_q   <= drive_d | float_d;  // RQ11
    end
  end

  // next values of the falling edge output group
  always_comb
  begin
    tdo_d    = tdo_q;
    tdo_oe_d = (st_q == JBT_ST_SIR) || (st_q == JBT_ST_SDR);  // RQ18
    if (st_q == JBT_ST_SIR)
      tdo_d = ir_sh_q[0];               // RQ1
    else if (st_q == JBT_ST_SDR)
    begin
      if (ir_q == JBT_INS_IDCODE)
        tdo_d = id_sh_q[0];
      else if (dr_boundary)
        tdo_d = bs_sh_q[0];
      else
        tdo_d = byp_q;                  // RQ10
    end
  end

  // tdo changes on the falling tck edge
  always_ff @(negedge tck or negedge resetn)
  begin
    if (!resetn)
    begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else
    begin
      tdo_q    <= tdo_d;                // RQ16
      tdo_oe_q <= tdo_oe_d;             // RQ18
    end
  end

  // test mode levels cross into the core clock domain
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_m_q         <= 1'b0;
      float_m_q        <= 1'b0;
      core_test_hold_q <= 1'b0;
      core_float_q     <= 1'b0;
    end
    else
    begin
      hold_m_q         <= hold_src_q;  // RQ11
      float_m_q        <= bs_float_q;
      core_test_hold_q <= hold_m_q;
      core_float_q     <= float_m_q;
    end
  end

  // checks on the tck domain
  sequence s_tms_reset;
    tms [*5];
  endsequence

  sequence s_bypass_shift;
    (st_q == JBT_ST_SDR && ir_q == JBT_INS_BYPASS) ##1 (st_q == JBT_ST_SDR);
  endsequence

  chk_tms_reset_five: assert property (@(posedge tck) disable iff (!resetn) // RQ15
    s_tms_reset |=> (st_q == JBT_ST_TLR))
    else $error("five tms highs did not reach test-logic-reset");

  chk_reset_selects_id: assert property (@(posedge tck) disable iff (!resetn) // RQ5
    (st_q == JBT_ST_TLR) |=> (ir_q == JBT_INS_IDCODE))
    else $error("device code not active after test-logic-reset");

  chk_id_capture_value: assert property (@(posedge tck) disable iff (!resetn) // RQ4
    (st_q == JBT_ST_CDR && ir_q == JBT_INS_IDCODE) |=> (id_sh_q == JBT_ID_VALUE))
    else $error("device code not captured");

  chk_tdo_drive_window: assert property (@(posedge tck) disable iff (!resetn) // RQ18
    tdo_oe_q == (st_q == JBT_ST_SIR || st_q == JBT_ST_SDR))
    else $error("tdo enable outside shift states");

  chk_bypass_one_bit: assert property (@(posedge tck) disable iff (!resetn) // RQ10
    s_bypass_shift |-> (tdo_q == $past(tdi)))
    else $error("bypass path is not one cell long");

  chk_extest_drives: assert property (@(posedge tck) disable iff (!resetn) // RQ2
    (st_q == JBT_ST_UIR && ir_sh_q == JBT_INS_EXTEST) |=> (bs_drive_q && !bs_float_q))
    else $error("external test did not enable outputs at update-ir");

  chk_samplez_floats: assert property (@(posedge tck) disable iff (!resetn) // RQ6
    (st_q == JBT_ST_UIR && ir_sh_q == JBT_INS_SAMPLEZ) |=> (bs_float_q && !bs_drive_q))
    else $error("sample with floating outputs did not float");

  chk_sample_capture: assert property (@(posedge tck) disable iff (!resetn) // RQ8
    (st_q == JBT_ST_CDR && ir_q == JBT_INS_SAMPLE) |=> (bs_sh_q == $past(pad_s_q)))
    else $error("boundary chain missed the sampled pads");

  chk_preload_update: assert property (@(posedge tck) disable iff (!resetn) // RQ2
    (st_q == JBT_ST_UDR && ir_q == JBT_INS_SAMPLE) |=> (bs_pad_out_q == $past(bs_sh_q)))
    else $error("preload not moved to update stage");

  chk_ir_capture_code: assert property (@(posedge tck) disable iff (!resetn) // RQ17
    (st_q == JBT_ST_CIR) |=> (ir_sh_q == JBT_IR_CAPTURE))
    else $error("instruction capture pattern wrong");

endmodule

// ==== tb/jbt_ctl_model.sv ====
// boundary-scan controller model that drives the serial test link
`timescale 1ns/1ns
module jbt_ctl_model (
  output logic      tck,      // test clock, stands low between frames
  output logic      tms,      // mode select
  output logic      tdi,      // serial data to the port
  input  wire logic tdo_q,    // serial data from the port
  input  wire logic tdo_oe_q  // port drives tdo
);
  logic last_q;  // last level seen while tdo was driven
  logic pin;     // level at the tdo ball
  // a released tdo shows the inverse of its last driven level
  assign pin = tdo_oe_q ? tdo_q : ~last_q;
  // idle levels: lines pulled up, clock still
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    last_q = 1'b0;
  end
  // one 125 ns test clock period; tdo is read at the rising edge
  task automatic cyc(input logic t, input logic d, output logic s);
    tms = t;
    tdi = d;
    #31;
    tck = 1'b1;
    s = pin;
    if (tdo_oe_q)
      last_q = tdo_q;
    #62;
    tck = 1'b0;
    #32;
  endtask
  // five tms-high edges reach test-logic-reset, then idle
  task automatic reset_tap();
    logic s;
    repeat (5) cyc(1'b1, 1'b1, s);
    cyc(1'b0, 1'b1, s);
    tms = 1'b1;
  endtask
  // one scan from run-test-idle, lsb first, back to idle
  task automatic scan(input logic ir, input logic [108:0] din, input int n,
                      output logic [108:0] dout);
    logic s;
    dout = '0;
    cyc(1'b1, 1'b1, s);
    if (ir)
      cyc(1'b1, 1'b1, s);
    cyc(1'b0, 1'b1, s);
    cyc(1'b0, 1'b1, s);
    for (int i = 0; i < n; i++)
    begin
      cyc(i == n - 1, din[i], s);
      dout[i] = s;
    end
    cyc(1'b1, 1'b1, s);
    cyc(1'b0, 1'b1, s);
    tms = 1'b1;
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the boundary-scan test access port
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  import jbt_pkg::*;
  logic         clk_sys, resetn, tck, tms, tdi, tdo_q, tdo_oe_q;  // link and core
  logic [108:0] bs_pad_in, bs_pad_out_q, got;                     // boundary vectors
  logic         bs_drive_q, bs_float_q, core_test_hold_q, core_float_q;
  int           bad_count, samples_checked;                       // report counters
  localparam logic [108:0] PAT_A = {{27{4'ha}}, 1'h1};  // pad pattern
  localparam logic [108:0] PAT_P = {{27{4'h3}}, 1'h0};  // preload vector
  // core clock, 10 ns
  always #5 clk_sys = ~clk_sys;
  jbt_tap DUT (.clk_sys(clk_sys), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .bs_pad_in(bs_pad_in),
    .bs_pad_out_q(bs_pad_out_q), .bs_drive_q(bs_drive_q), .bs_float_q(bs_float_q),
    .core_test_hold_q(core_test_hold_q), .core_float_q(core_float_q));
  jbt_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q),
    .tdo_oe_q(tdo_oe_q));
  // counts, verdict, end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // power-up pulse, then the link is brought to idle
  task automatic power_up();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    u_ctl.reset_tap();
  endtask
  // pads change only well away from the capture edge
  task automatic set_pads(input logic [108:0] v);
    @(posedge clk_sys);
    bs_pad_in <= v;
    repeat (2) @(posedge clk_sys);
  endtask
  // core side crossing takes 2-3 core edges
  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask
  // device code shifted without loading an instruction
  task automatic t_idcode();
    u_ctl.scan(1'b0, '0, 32, got);
    `CHK("device code", JBT_ID_VALUE, got[31:0])
    `CHK("tdo enable idle", 1'b0, tdo_oe_q)
    $display("test idcode done");
  endtask
  // instruction capture pattern, then single bypass cell; only defined codes used
  task automatic t_bypass();
    u_ctl.scan(1'b1, {106'h0, JBT_INS_BYPASS}, 3, got);
    `CHK("ir capture", JBT_IR_CAPTURE, got[2:0])
    u_ctl.scan(1'b0, 109'hb, 4, got);
    `CHK("bypass path", 4'h6, got[3:0])
    $display("test bypass done");
  endtask
  // sample with preload, then external test drives the vector
  task automatic t_extest();
    set_pads(PAT_A);
    u_ctl.scan(1'b1, {106'h0, JBT_INS_SAMPLE}, 3, got);
    u_ctl.scan(1'b0, PAT_P, 109, got);
    `CHK("sampled pads", PAT_A, got)
    u_ctl.scan(1'b1, {106'h0, JBT_INS_EXTEST}, 3, got);
    `CHK("drive on", 1'b1, bs_drive_q)
    `CHK("preload out", PAT_P, bs_pad_out_q)
    set_pads(~PAT_A);
    u_ctl.scan(1'b0, '0, 109, got);
    `CHK("input capture", ~PAT_A, got)
    settle();
    `CHK("core hold", 1'b1, core_test_hold_q)
    $display("test extest done");
  endtask
  // outputs float while pads are still captured
  task automatic t_samplez();
    set_pads(PAT_P);
    u_ctl.scan(1'b1, {106'h0, JBT_INS_SAMPLEZ}, 3, got);
    u_ctl.scan(1'b0, '1, 109, got);
    `CHK("float capture", PAT_P, got)
    `CHK("float on", 1'b1, bs_float_q)
    settle();
    `CHK("core float", 1'b1, core_float_q)
    $display("test samplez done");
  endtask
  // tms reset clears float and restores the device code
  task automatic t_tms_reset();
    u_ctl.reset_tap();
    `CHK("float off", 1'b0, bs_float_q)
    settle();
    `CHK("core float off", 1'b0, core_float_q)
    `CHK("core hold off", 1'b0, core_test_hold_q)
    t_idcode();
  endtask
  // main sequence
  initial
  begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    bs_pad_in = '0;
    bad_count = 0;
    samples_checked = 0;
    power_up();
    t_idcode();
    t_bypass();
    t_extest();
    power_up();
    t_idcode();
    t_samplez();
    t_tms_reset();
    wrap_up();
  end
  // hang guard
  initial
  begin
    #500000;
    bad_count++;
    wrap_up();
  end
endmodule
